// ==== design/tmr_pkg.sv ====
// Operation
// - link clock is the pixel clock, one period per pixel
// - each lane carries one 10-bit character per 8-bit component
// - lanes oversampled 4x per bit, up to one pixel of lane skew tolerated
// - four sampling phases at ten times pixel rate locate each lane's bits
// - data characters are transition-minimized, blanking ones transition-maximized
// - bit alignment per lane, acquired in blanking, kept while link active
// - horizontal sync jitter of one pixel early or late is absorbed
// - horizontal sync is rebuilt from data enable and the pixel clock
// - horizontal sync edges are snapped to a fixed place relative to data
// - a stable horizontal sync passes through unchanged
// - pixels-per-clock select: 0 one pixel, 1 two pixels per clock
// - latch edge select: 0 falling edge, 1 rising edge
// - clock gate select: 0 free-running, 1 clock gated low in blanking
// - power-down low floats all outputs except link flag and control bit 1
// - power-down input defaults to normal driving when left open
// - red on lane 2, green on lane 1, blue on lane 0
// - link flag drops after 1e6 idle pixels, rises on two enable edges in 1024
// - output clock period is two pixels in pair mode, else one

package tmr_pkg;

  localparam int LANES  = 3;
  localparam int CHAR_W = 10;
  localparam int OVS    = 4;
  localparam int SAMP_W = CHAR_W * OVS;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [3:0] CONFIG_OFS   = 4'h0;
  localparam logic [3:0] STATUS_OFS   = 4'h4;
  localparam int         CFG_PIXS_BIT = 0;
  localparam int         CFG_EDGE_BIT = 1;
  localparam int         CFG_GATE_BIT = 2;
  localparam logic [2:0] CONFIG_RESET = 3'h0;

  // ---------------------------------------------------------------
  // line coding and timing
  // ---------------------------------------------------------------
  localparam logic [9:0] CTRL_CODE0 = 10'h354;
  localparam logic [9:0] CTRL_CODE1 = 10'h0AB;
  localparam logic [9:0] CTRL_CODE2 = 10'h154;
  localparam logic [9:0] CTRL_CODE3 = 10'h2AB;
  localparam int PHASE_WINDOW   = 64;
  localparam int LOCK_MATCHES   = 8;
  localparam int ACTIVE_WINDOW  = 1024;
  localparam int INACTIVE_PIX   = 1000000;
  localparam int REGEN_DELAY    = 2;

  typedef enum logic [1:0] {
    LANE_PHASE  = 2'b00,
    LANE_SEARCH = 2'b01,
    LANE_LOCKED = 2'b10
  } tmr_lane_state_e;

  function automatic logic tmr_is_ctrl(input logic [9:0] c);
    return (c == CTRL_CODE0) || (c == CTRL_CODE1) ||
           (c == CTRL_CODE2) || (c == CTRL_CODE3);
  endfunction

  function automatic logic [1:0] tmr_ctrl_bits(input logic [9:0] c);
    case (c)
      CTRL_CODE1: return 2'h1;
      CTRL_CODE2: return 2'h2;
      CTRL_CODE3: return 2'h3;
      default:    return 2'h0;
    endcase
  endfunction

  function automatic logic [7:0] tmr_decode(input logic [9:0] c);
    logic [7:0] d;
    logic [7:0] q;
    d = c[9] ? ~c[7:0] : c[7:0];
    q[0] = d[0];
    for (int i = 1; i < 8; i++)
      q[i] = c[8] ? (d[i] ^ d[i-1]) : ~(d[i] ^ d[i-1]);
    return q;
  endfunction

  function automatic logic [9:0] tmr_pick(input logic [SAMP_W-1:0] s,
                                          input logic [1:0] ph);
    logic [9:0] b;
    b = '0;
    for (int i = 0; i < CHAR_W; i++)
      b[i] = s[OVS*i + int'(ph)];
    return b;
  endfunction

  function automatic logic [3:0] tmr_edges(input logic [SAMP_W-1:0] s,
                                           input int k);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < CHAR_W; i++)
      if ((OVS*i + k) > 0 && s[OVS*i + k] != s[OVS*i + k - 1])
        n = n + 4'h1;
    return n;
  endfunction

endpackage

// ==== design/tmr_receiver.sv ====
`timescale 1ns/1ps
module tmr_receiver
  import tmr_pkg::*;
#(
  parameter int INACTIVE_PIXELS = INACTIVE_PIX
)(
  input  wire logic                    clock_i,
  input  wire logic                    reset_n_i,
  input  wire logic                    wb_cyc_i,
  input  wire logic                    wb_stb_i,
  input  wire logic                    wb_we_i,
  input  wire logic [3:0]              wb_adr_i,
  input  wire logic [31:0]             wb_dat_i,
  input  wire logic [3:0]              wb_sel_i,
  output logic      [31:0]             wb_dat_o,
  output logic                         wb_ack_o,
  input  wire logic                    link_clock_i,
  input  wire logic [LANES*SAMP_W-1:0] lane_samples_i,
  input  wire logic                    output_driver_powerdown_n_i,
  output logic      [23:0]             even_pixel_bus_o,
  output logic      [23:0]             odd_pixel_bus_o,
  output logic                         data_enable_o,
  output logic                         hsync_o,
  output logic                         vsync_o,
  output logic                         user_control_bit1_o,
  output logic                         user_control_bit2_o,
  output logic                         user_control_bit3_o,
  output logic                         output_pixel_clock_o,
  output logic                         outputs_enable_o,
  output logic                         link_active_flag_o
);

  localparam int IDLE_W = $clog2(INACTIVE_PIXELS + ACTIVE_WINDOW + 1);

  // ---------------------------------------------------------------
  // synchronisers
  // ---------------------------------------------------------------
  logic [2:0]              lclk_sync;
  logic [LANES*SAMP_W-1:0] samp_s1;
  logic [LANES*SAMP_W-1:0] samp_s2;
  logic                    pdo_s1;
  logic                    pdo_s2;

  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      lclk_sync <= 3'h0;
      samp_s1   <= '0;
      samp_s2   <= '0;
      pdo_s1    <= 1'b1;
      pdo_s2    <= 1'b1;
    end
    else
    begin
      lclk_sync <= {lclk_sync[1:0], link_clock_i};
      samp_s1   <= lane_samples_i;
      samp_s2   <= samp_s1;
      pdo_s1    <= output_driver_powerdown_n_i;
      pdo_s2    <= pdo_s1;
    end
  end

  // one link clock edge per pixel
  wire pix_stb = lclk_sync[1] & ~lclk_sync[2];

  // half-period point, used by the one-pixel output clock
  logic [7:0] per_cnt;
  logic [7:0] per_len;
  wire        mid_stb = ~pix_stb & (per_cnt == {1'b0, per_len[7:1]});

  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      per_cnt <= 8'h0;
      per_len <= 8'h0;
    end
    else if (pix_stb)
    begin
      per_cnt <= 8'h1;
      per_len <= per_cnt;
    end
    else if (per_cnt != 8'hFF)
      per_cnt <= per_cnt + 8'h1;
  end

  // ---------------------------------------------------------------
  // per-lane phase pick and bit alignment
  // ---------------------------------------------------------------
  logic                      link_active;
  logic                      link_active_q;
  wire                       link_lost = link_active_q & ~link_active;
  wire  [LANES*CHAR_W-1:0]   raw_chars;
  wire  [LANES*CHAR_W-1:0]   dly_chars;
  wire  [LANES-1:0]          lane_locked;

  for (genvar l = 0; l < LANES; l++)
  begin : g_lane
    tmr_lane_state_e state;
    logic [1:0]      phase;
    logic [1:0]      best;
    logic [9:0]      edge_cnt [OVS];
    logic [6:0]      win_cnt;
    logic [9:0]      hist_prev;
    logic [3:0]      offset;
    logic [3:0]      cand;
    logic [3:0]      match_cnt;
    logic [9:0]      chr;
    logic [9:0]      chr_d;
    logic            found;
    logic [3:0]      found_ofs;
    wire [SAMP_W-1:0] s = samp_s2[l*SAMP_W +: SAMP_W];
    // ten bits, one in four samples
    wire [9:0]  bits_now = tmr_pick(s, phase);
    wire [19:0] hist     = {bits_now, hist_prev};

    // sample farthest from the busiest edge phase
    always_comb
    begin
      best = 2'h0;
      for (int k = 1; k < OVS; k++)
        if (edge_cnt[k] > edge_cnt[best])
          best = 2'(k);
    end

    // blanking characters mark the bit boundary
    always_comb
    begin
      found     = 1'b0;
      found_ofs = 4'h0;
      for (int o = CHAR_W - 1; o >= 0; o--)
        if (tmr_is_ctrl(hist[o +: CHAR_W]))
        begin
          found     = 1'b1;
          found_ofs = 4'(o);
        end
    end

    always_ff @(posedge clock_i or negedge reset_n_i)
    begin
      if (!reset_n_i)
      begin
        state     <= LANE_PHASE;
        phase     <= 2'h0;
        win_cnt   <= 7'h0;
        hist_prev <= 10'h0;
        offset    <= 4'h0;
        cand      <= 4'h0;
        match_cnt <= 4'h0;
        chr       <= 10'h0;
        chr_d     <= 10'h0;
        for (int k = 0; k < OVS; k++)
          edge_cnt[k] <= 10'h0;
      end
      // lock dropped only when the link goes inactive
      else if (link_lost)
      begin
        state   <= LANE_PHASE;
        win_cnt <= 7'h0;
        for (int k = 0; k < OVS; k++)
          edge_cnt[k] <= 10'h0;
      end
      else if (pix_stb)
      begin
        hist_prev <= bits_now;
        chr       <= hist[offset +: CHAR_W];
        chr_d     <= chr;
        case (state)
          LANE_PHASE:
          begin
            for (int k = 0; k < OVS; k++)
              edge_cnt[k] <= edge_cnt[k] + {6'h0, tmr_edges(s, k)};
            win_cnt <= win_cnt + 7'h1;
            if (win_cnt == 7'(PHASE_WINDOW - 1))
            begin
              phase <= best + 2'h2;
              state <= LANE_SEARCH;
              for (int k = 0; k < OVS; k++)
                edge_cnt[k] <= 10'h0;
            end
          end
          LANE_SEARCH:
          begin
            // eight matches fit well inside a blanking gap
            if (found && found_ofs == cand)
            begin
              match_cnt <= match_cnt + 4'h1;
              if (match_cnt == 4'(LOCK_MATCHES - 1))
              begin
                offset <= cand;
                state  <= LANE_LOCKED;
              end
            end
            else if (found)
            begin
              cand      <= found_ofs;
              match_cnt <= 4'h1;
            end
            else
              match_cnt <= 4'h0;
          end
          LANE_LOCKED:
            state <= LANE_LOCKED;
          default:
            state <= LANE_PHASE;
        endcase
      end
    end

    assign raw_chars[l*CHAR_W +: CHAR_W] = chr;
    assign dly_chars[l*CHAR_W +: CHAR_W] = chr_d;
    assign lane_locked[l]                = (state == LANE_LOCKED);
  end

  // ---------------------------------------------------------------
  // lane deskew
  // ---------------------------------------------------------------
  logic [LANES-1:0] delay_sel;
  logic             skew_done;
  logic [LANES-1:0] raw_de;

  always_comb
  begin
    for (int l = 0; l < LANES; l++)
      raw_de[l] = ~tmr_is_ctrl(raw_chars[l*CHAR_W +: CHAR_W]);
  end

  // early lanes wait one character for the late ones
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      delay_sel <= '0;
      skew_done <= 1'b0;
    end
    else if (lane_locked != '1)
    begin
      delay_sel <= '0;
      skew_done <= 1'b0;
    end
    else if (pix_stb && !skew_done && raw_de != '0)
    begin
      delay_sel <= (raw_de == '1) ? '0 : raw_de;
      skew_done <= 1'b1;
    end
  end

  logic [9:0] lane_chr [LANES];
  always_comb
  begin
    for (int l = 0; l < LANES; l++)
      lane_chr[l] = delay_sel[l] ? dly_chars[l*CHAR_W +: CHAR_W]
                                 : raw_chars[l*CHAR_W +: CHAR_W];
  end

  // blue lane 0, green lane 1, red lane 2
  wire        de_now  = skew_done & ~tmr_is_ctrl(lane_chr[0]) &
                        ~tmr_is_ctrl(lane_chr[1]) & ~tmr_is_ctrl(lane_chr[2]);
  wire [23:0] pix_now = {tmr_decode(lane_chr[2]), tmr_decode(lane_chr[1]),
                         tmr_decode(lane_chr[0])};
  wire [1:0]  c0_now  = tmr_ctrl_bits(lane_chr[0]);
  wire [1:0]  c1_now  = tmr_ctrl_bits(lane_chr[1]);
  wire [1:0]  c2_now  = tmr_ctrl_bits(lane_chr[2]);

  // ---------------------------------------------------------------
  // decode stage, delay line and sync regeneration
  // ---------------------------------------------------------------
  logic        de_s0;
  logic        hs_s0;
  logic [27:0] vid_d [REGEN_DELAY + 1];
  logic [15:0] line_cnt;
  logic [15:0] edge_ref [2];
  logic [1:0]  armed;
  logic        hs_regen;
  logic [1:0]  hs_ev;
  logic [1:0]  fire;

  wire hs_now = de_now ? hs_s0 : c0_now[0];
  wire [15:0] hpos = (de_s0 && !de_now) ? 16'hFFFF : line_cnt;
  assign hs_ev = {hs_s0 & ~hs_now, hs_now & ~hs_s0};

  function automatic logic near_ref(input logic [15:0] a,
                                    input logic [15:0] r);
    return (a == r) || (a == 16'(r + 16'h1)) || (16'(a + 16'h1) == r);
  endfunction

  always_comb
  begin
    for (int e = 0; e < 2; e++)
      fire[e] = armed[e] & (line_cnt == 16'(edge_ref[e] + REGEN_DELAY));
  end

  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      de_s0    <= 1'b0;
      hs_s0    <= 1'b0;
      line_cnt <= 16'h0;
      armed    <= 2'h0;
      hs_regen <= 1'b0;
      for (int e = 0; e < 2; e++)
        edge_ref[e] <= 16'h0;
      for (int i = 0; i <= REGEN_DELAY; i++)
        vid_d[i] <= 28'h0;
    end
    else if (pix_stb)
    begin
      de_s0 <= de_now;
      hs_s0 <= hs_now;
      // controls hold their blanking value through active video
      vid_d[0] <= {de_now, pix_now,
                   de_now ? vid_d[0][2:0] : {c2_now, c1_now[1]}};
      for (int i = 1; i <= REGEN_DELAY; i++)
        vid_d[i] <= vid_d[i-1];
      // line position counted from the end of data enable
      if (de_s0 && !de_now)
        line_cnt <= 16'h0;
      else if (line_cnt != 16'hFFFF)
        line_cnt <= line_cnt + 16'h1;
      for (int e = 0; e < 2; e++)
      begin
        // output edge placed at the remembered position
        if (fire[e])
        begin
          armed[e] <= 1'b0;
          hs_regen <= (e == 0);
        end
        // one pixel either way keeps the old position
        if (hs_ev[e])
        begin
          armed[e]    <= 1'b1;
          edge_ref[e] <= near_ref(hpos, edge_ref[e]) ? edge_ref[e]
                                                     : hpos;
        end
      end
    end
  end

  // vsync runs beside vid_d in vs_s0 and vs_d, with the same delay
  logic vs_s0;
  logic [REGEN_DELAY-1:0] vs_d;
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      vs_s0 <= 1'b0;
      vs_d  <= '0;
    end
    else if (pix_stb)
    begin
      vs_s0 <= de_now ? vs_s0 : c0_now[1];
      vs_d  <= {vs_d[REGEN_DELAY-2:0], vs_s0};
    end
  end

  // ---------------------------------------------------------------
  // link activity
  // ---------------------------------------------------------------
  logic [IDLE_W-1:0] idle_cnt;
  logic              tr_seen;

  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      idle_cnt      <= '0;
      tr_seen       <= 1'b0;
      link_active   <= 1'b0;
      link_active_q <= 1'b0;
    end
    else
    begin
      link_active_q <= link_active;
      if (pix_stb && de_now != de_s0)
      begin
        idle_cnt <= '0;
        tr_seen  <= 1'b1;
        if (tr_seen && idle_cnt < IDLE_W'(ACTIVE_WINDOW))
          link_active <= 1'b1;
      end
      else if (pix_stb && idle_cnt != IDLE_W'(INACTIVE_PIXELS))
        idle_cnt <= idle_cnt + IDLE_W'(1);
      else if (idle_cnt == IDLE_W'(INACTIVE_PIXELS))
      begin
        link_active <= 1'b0;
        tr_seen     <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // output formatting
  // ---------------------------------------------------------------
  logic [2:0]  cfg;
  logic        pair_odd;
  logic [23:0] even_hold;
  logic        ck_base;

  wire [27:0] vo     = vid_d[REGEN_DELAY];
  wire        pixs   = cfg[CFG_PIXS_BIT];
  wire        vo_de  = vo[27];
  wire        launch = pix_stb & (~pixs | pair_odd);
  wire        next_de = launch ? vo_de : data_enable_o;
  // pair mode holds the clock high for one pixel and low for the next
  wire next_base = pixs ? (pix_stb ? launch : ck_base)
                        : (pix_stb ? 1'b1 : (mid_stb ? 1'b0 : ck_base));
  // rising latch edge inverts the clock
  // gating holds the clock low in blanking
  wire next_ck = (cfg[CFG_GATE_BIT] & ~next_de) ? 1'b0
                                                : next_base ^ cfg[CFG_EDGE_BIT];

  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      pair_odd             <= 1'b0;
      even_hold            <= 24'h0;
      ck_base              <= 1'b0;
      output_pixel_clock_o <= 1'b0;
      even_pixel_bus_o     <= 24'h0;
      odd_pixel_bus_o      <= 24'h0;
      data_enable_o        <= 1'b0;
      hsync_o              <= 1'b0;
      vsync_o              <= 1'b0;
      user_control_bit1_o  <= 1'b0;
      user_control_bit2_o  <= 1'b0;
      user_control_bit3_o  <= 1'b0;
      outputs_enable_o     <= 1'b1;
      link_active_flag_o   <= 1'b0;
    end
    else
    begin
      ck_base              <= next_base;
      output_pixel_clock_o <= next_ck;
      // only link flag and control bit 1 stay driven
      // data keeps running so the release is immediate
      outputs_enable_o     <= pdo_s2;
      link_active_flag_o   <= link_active;
      // first of a pair waits for its partner
      if (pix_stb)
      begin
        pair_odd  <= pixs & ~pair_odd & ~(vid_d[REGEN_DELAY-1][27] & ~vo_de);
        even_hold <= vo[26:3];
      end
      // one or two pixels per launch
      if (launch)
      begin
        even_pixel_bus_o    <= pixs ? even_hold : vo[26:3];
        odd_pixel_bus_o     <= pixs ? vo[26:3] : 24'h0;
        data_enable_o       <= vo_de;
        // stable input comes out delayed like data
        hsync_o             <= hs_regen;
        vsync_o             <= vs_d[REGEN_DELAY-1];
        user_control_bit1_o <= vo[0];
        user_control_bit2_o <= vo[1];
        user_control_bit3_o <= vo[2];
      end
    end
  end

  // ---------------------------------------------------------------
  // wishbone slave
  // ---------------------------------------------------------------
  wire        wb_req  = wb_cyc_i & wb_stb_i;
  wire        hit_cfg = (wb_adr_i == CONFIG_OFS);
  wire        hit_st  = (wb_adr_i == STATUS_OFS);
  wire [31:0] rd_mux  = hit_cfg ? {29'h0, cfg}
                      : hit_st  ? {27'h0, skew_done, lane_locked, link_active}
                      : 32'h0;

  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
      cfg      <= CONFIG_RESET;
    end
    else
    begin
      wb_ack_o <= wb_req & ~wb_ack_o;
      if (wb_req && !wb_ack_o)
        wb_dat_o <= rd_mux;
      if (wb_req && wb_ack_o && wb_we_i && hit_cfg && wb_sel_i[0])
        cfg <= wb_dat_i[2:0];
    end
  end

endmodule // tmr_receiver

// ==== verif/tmr_receiver_chk.sv ====
`timescale 1ns/1ps
module tmr_receiver_chk
  import tmr_pkg::*;
#(
  parameter int INACTIVE_PIXELS = INACTIVE_PIX
)(
  input wire logic        clock_i,
  input wire logic        reset_n_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [3:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        link_clock_i,
  input wire logic        output_driver_powerdown_n_i,
  input wire logic        data_enable_o,
  input wire logic        outputs_enable_o,
  input wire logic        link_active_flag_o
);
  // ----------------------------------
  // pixels since last output de change
  // ----------------------------------
  logic [1:0]  lc_q;
  logic        de_q;
  logic [31:0] idle;
  always_ff @(posedge clock_i or negedge reset_n_i)
    if (!reset_n_i)
    begin
      lc_q <= 2'h0;
      de_q <= 1'b0;
      idle <= 32'h0;
    end
    else
    begin
      lc_q <= {lc_q[0], link_clock_i};
      de_q <= data_enable_o;
      idle <= (de_q != data_enable_o) ? 32'h0 : idle + 32'(lc_q == 2'b01);
    end

  // ----------
  // properties
  // ----------
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!reset_n_i);
  property p_ack_answer;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("no ack");
  property p_ack_drop;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("ack held");
  property p_ack_cause;
    wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("stray ack");
  property p_unmapped;
    wb_ack_o && !wb_we_i && wb_adr_i != CONFIG_OFS && wb_adr_i != STATUS_OFS
      |-> wb_dat_o == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped data");
  property p_cfg_width;
    wb_ack_o && !wb_we_i && wb_adr_i == CONFIG_OFS |-> wb_dat_o[31:3] == 29'h0;
  endproperty
  a_cfg_width: assert property (p_cfg_width) else $error("config bits");
  property p_pd_float;
    !output_driver_powerdown_n_i [*5] |-> !outputs_enable_o;
  endproperty
  a_pd_float: assert property (p_pd_float) else $error("no float");
  property p_pd_resume;
    output_driver_powerdown_n_i [*5] |-> outputs_enable_o;
  endproperty
  a_pd_resume: assert property (p_pd_resume) else $error("no drive");
  property p_flag_fall;
    $fell(link_active_flag_o) |-> idle >= INACTIVE_PIXELS - 16;
  endproperty
  a_flag_fall: assert property (p_flag_fall) else $error("early drop");
  c_write: cover property (wb_ack_o && wb_we_i);
  c_float: cover property (!outputs_enable_o);
  c_drop: cover property ($fell(link_active_flag_o));
endmodule // tmr_receiver_chk

bind tmr_receiver tmr_receiver_chk #(
  .INACTIVE_PIXELS(INACTIVE_PIXELS)
) u_chk (
  .clock_i(clock_i), .reset_n_i(reset_n_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .link_clock_i(link_clock_i),
  .output_driver_powerdown_n_i(output_driver_powerdown_n_i),
  .data_enable_o(data_enable_o), .outputs_enable_o(outputs_enable_o),
  .link_active_flag_o(link_active_flag_o)
);

// ==== verif/tmr_tx_model.sv ====
`timescale 1ns/1ps
module tmr_tx_model
  import tmr_pkg::*;
(
  input  wire logic                    run_i,
  output logic                         link_clock_o,
  output logic [LANES*SAMP_W-1:0]      lane_samples_o
);
  // --------------
  // line generator
  // --------------
  localparam int BLANK = 130;
  localparam int LINE  = 146;
  int         pix;
  logic [9:0] ch [LANES];
  function automatic logic [9:0] enc(input logic [7:0] q);
    logic [9:0] c;
    c = 10'h100;
    c[0] = q[0];
    for (int i = 1; i < 8; i++)
      c[i] = q[i] ^ c[i-1];
    return c;
  endfunction
  initial
  begin
    link_clock_o   = 1'b0;
    lane_samples_o = '0;
    pix            = 0;
  end
  always #62.5 link_clock_o = ~link_clock_o;
  // lanes change mid-pixel
  always @(negedge link_clock_o)
  begin
    pix = (pix + 1) % LINE;
    // blanking codes, then red, green, blue pixels
    if (run_i && pix >= BLANK)
    begin
      ch[2] = enc(8'(pix - BLANK + 33));
      ch[1] = enc(8'(pix - BLANK + 65));
      ch[0] = enc(8'(pix - BLANK + 1));
    end
    else
    begin
      ch[2] = CTRL_CODE0;
      ch[1] = CTRL_CODE0;
      ch[0] = (pix < 8) ? CTRL_CODE1 : CTRL_CODE0;
    end
    // ten bits per pixel, four samples per bit
    for (int l = 0; l < LANES; l++)
      for (int i = 0; i < CHAR_W; i++)
        lane_samples_o[SAMP_W*l + OVS*i +: OVS] = {OVS{ch[l][i]}};
  end
endmodule // tmr_tx_model

// ==== verif/test_tmr_receiver.sv ====
`timescale 1ns/1ps
module test_tmr_receiver
  import tmr_pkg::*;
;
  localparam int INACT = 200;
  typedef struct packed {
    logic [3:0]  a;
    logic [31:0] d;
    logic [3:0]  s;
    logic [31:0] e;
  } tmr_row_s;
  tmr_row_s rows [6] = '{'{4'h0, 32'h5, 4'h1, 32'h5},
    '{4'h0, 32'h2, 4'h0, 32'h5}, '{4'h0, 32'hFFFFFFFF, 4'hF, 32'h7},
    '{4'h8, 32'h3, 4'hF, 32'h0}, '{4'hC, 32'h1, 4'hF, 32'h0},
    '{4'h0, 32'h0, 4'h1, 32'h0}};
  logic clock_i = 1'b0, reset_n_i = 1'b0, cyc = 1'b0, stb = 1'b0;
  logic we = 1'b0, pdn = 1'b1, run = 1'b1, tie = 1'b0, opc_q = 1'b0;
  logic [3:0]  adr = 4'h0, sel = 4'h0;
  logic [31:0] wdat = 32'h0, r, rdat;
  logic        ack, lclk, de, opc, oe, flag, hs;
  logic [23:0] even, odd;
  logic [2:0]  cfg = 3'h0;
  logic [47:0] seen [$];
  logic [LANES*SAMP_W-1:0] samples;
  int bad, errors, checked, n;

  always #2.5 clock_i = ~clock_i;

  tmr_receiver #(.INACTIVE_PIXELS(INACT)) dut (
    .clock_i(clock_i), .reset_n_i(reset_n_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat),
    .wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack), .link_clock_i(lclk),
    .lane_samples_i(samples), .output_driver_powerdown_n_i(pdn),
    .even_pixel_bus_o(even), .odd_pixel_bus_o(odd), .data_enable_o(de),
    .hsync_o(hs), .vsync_o(), .user_control_bit1_o(), .user_control_bit2_o(),
    .user_control_bit3_o(), .output_pixel_clock_o(opc),
    .outputs_enable_o(oe), .link_active_flag_o(flag));
  tmr_tx_model u_tx (.run_i(run), .link_clock_o(lclk),
    .lane_samples_o(samples));

  // -----------------------------------------
  // latch-edge capture and gated clock watch
  // -----------------------------------------
  always @(posedge clock_i)
  begin
    opc_q <= opc;
    if (tie)
      pdn <= flag;
    if (opc_q !== opc && opc === cfg[1] && de === 1'b1)
      seen.push_back({even, odd});
    if (cfg[2] && de === 1'b0 && opc === 1'b1)
      bad++;
  end

  // -----
  // tasks
  // -----
  task automatic check(input string what, input logic [47:0] got, exp);
    checked++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    int k;
    @(posedge clock_i);
    {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, s};
    k = 0;
    do
    begin
      @(posedge clock_i);
      k++;
    end
    while (ack !== 1'b1 && k < 50);
    r = rdat;
    errors += int'(k >= 50);
    {cyc, stb} <= 2'b00;
  endtask
  task automatic wait_for(ref logic s, input logic v, input int lim);
    n = 0;
    while (s !== v && n < lim)
    begin
      @(posedge clock_i);
      n++;
    end
    errors += int'(n >= lim);
  endtask
  function automatic logic [23:0] px(input int p);
    return {8'(p + 32), 8'(p + 64), 8'(p)};
  endfunction
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    repeat (99000) @(posedge clock_i);
    errors++;
    final_report();
  end

  initial
  begin
    repeat (8) @(posedge clock_i);
    check("enable", oe, 1'b1);
    check("flag", flag, 1'b0);
    check("even", even, 24'h0);
    reset_n_i <= 1'b1;
    $display("reset test done");
    wb(1'b0, CONFIG_OFS, 32'h0, 4'hF);
    check("config", r, 32'(CONFIG_RESET));
    foreach (rows[i])
    begin
      wb(1'b1, rows[i].a, rows[i].d, rows[i].s);
      wb(1'b0, rows[i].a, 32'h0, 4'hF);
      check("register", r, rows[i].e);
    end
    $display("register test done");
    wait_for(flag, 1'b1, 40000);
    for (int m = 0; m < 8; m++)
    begin
      wb(1'b1, CONFIG_OFS, 32'(m), 4'h1);
      cfg = 3'(m);
      wait_for(de, 1'b1, 9000);
      wait_for(de, 1'b0, 9000);
      seen.delete();
      bad = 0;
      wait_for(de, 1'b1, 9000);
      wait_for(de, 1'b0, 9000);
      check("hsync", hs, 1'b1);
      check("count", seen.size(), m[0] ? 8 : 16);
      for (int k = 0; k < seen.size(); k++)
        check("pixel", seen[k], m[0] ? {px(2*k+1), px(2*k+2)}
                                     : {px(k+1), 24'h0});
      check("gated", bad, 0);
      $display("mode %0d done", m);
    end
    pdn <= 1'b0;
    repeat (6) @(posedge clock_i);
    check("float", oe, 1'b0);
    check("flag kept", flag, 1'b1);
    pdn <= 1'b1;
    repeat (6) @(posedge clock_i);
    check("resume", oe, 1'b1);
    $display("power down test done");
    tie <= 1'b1;
    run <= 1'b0;
    wait_for(flag, 1'b0, (INACT + 200) * 25);
    check("idle span", n >= (INACT - 150) * 25, 1'b1);
    repeat (6) @(posedge clock_i);
    check("tied float", oe, 1'b0);
    run <= 1'b1;
    wait_for(flag, 1'b1, 40000);
    repeat (6) @(posedge clock_i);
    check("tied drive", oe, 1'b1);
    $display("link flag test done");
    final_report();
  end
endmodule // test_tmr_receiver
